// [inc/modem_regs_pkg.sv]
// Package: register map, field positions, symbol codes and timing for the modem mode/status bank
package modem_regs_pkg;

   // ********************************
   // Register map
   // ********************************
   localparam logic [3:0] ADDR_COMMAND = 4'h0;   // Task command register
   localparam logic [3:0] ADDR_CONTROL = 4'h1;   // Divider and loop bandwidth
   localparam logic [3:0] ADDR_MODE = 4'h2;      // Write-only mode register
   localparam logic [3:0] ADDR_STATUS = 4'h3;    // Status register

   // ********************************
   // Field positions and reset values
   // ********************************
   localparam int MODE_IRQ_EN_BIT = 7;
   localparam int MODE_INVERT_BIT = 6;
   localparam int MODE_TX_BIT = 5;
   localparam int MODE_EYE_BIT = 4;
   localparam int MODE_POWERSAVE_SEL_BIT = 3;
   localparam int STAT_IRQ_BIT = 7;
   localparam int STAT_FREE_BIT = 6;
   localparam int STAT_EMPTY_BIT = 5;
   localparam int STAT_OVF_BIT = 4;
   localparam int CTRL_DIV_LSB = 6;
   localparam int CTRL_BW_LSB = 0;
   localparam logic [7:0] MODE_RESET = 8'h00;
   localparam logic [7:0] CTRL_RESET = 8'h00;

   // ********************************
   // Task codes
   // ********************************
   localparam logic [7:0] TASK_NULL = 8'h00;
   localparam logic [7:0] TASK_RESET = 8'h01;

   // ********************************
   // Loop bandwidth codes
   // ********************************
   localparam logic [1:0] BW_HOLD = 2'h0;
   localparam logic [1:0] BW_WIDE = 2'h3;

   // ********************************
   // Symbol codes, two's complement in units of one
   // ********************************
   localparam logic [2:0] SYM_MID = 3'h0;   // Halfway between +1 and -1

   // ********************************
   // Timing
   // ********************************
   localparam int SETTLE_SYMBOLS = 20;          // Unsettled time after powersave exit
   localparam int DIV_BASE_LOG2 = 9;            // Code 00 divides by 512
   localparam logic [12:0] DIV_BASE = 13'h0200; // 512 clocks per symbol at code 00

   // ********************************
   // Carriers
   // ********************************
   typedef struct packed {
      logic irq_pin_enable;
      logic symbol_invert;
      logic tx_mode;
      logic rx_eye_test;
      logic powersave_sel;
   } mode_bits_t;

   typedef struct packed {
      logic irq_req;
      logic block_buffer_free;
      logic interleave_empty;
      logic deinterleave_overflow;
   } status_bits_t;

endpackage

// [src/modem_mode_status_regs.sv]
// Mode and status register bank of the four-level FSK packet modem
//
// Operation
// - Bandwidth field ignored in transmit, overridden acquiring
// - Hold disables loop feedback, nominal rate
// - Mode bit 7 enables low interrupt pin
// - Mode bit 6 inverts symbol polarity
// - Mode bit 5 selects transmit, cancels task
// - Eye test routes receive signal to output
// - Powersave disables filters, extraction, output buffer
// - Twenty symbols unsettled after leaving powersave
// - Interrupt request set on flag rising edges
// - Status read clears request, releases pin
// - Buffer free clears on real task write
// - Buffer free set with request when ready
// - Reset task or mode change sets free silently
// - Interleave empty set below two symbols
// - Empty silent set, clears, zero in receive
// - Empty buffer feeds mid-level symbol
// - Late receive task sets overflow and request
// - Overflow clears on read, reset, mode change
// - Divider codes give ratios 512 to 4096
`timescale 1ns/1ns
module modem_mode_status_regs
   import modem_regs_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Register port
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // Datapath events
   input wire logic tx_task_ready,
   input wire logic rx_task_done,
   input wire logic [1:0] interleave_level,
   input wire logic rx_task_late,
   input wire logic acquire_active,
   input wire logic pll_phase_nudge,
   input wire logic [2:0] tx_symbol_in,
   input wire logic [2:0] rx_eq_symbol,
   // Interrupt pin, open drain
   output logic irq_n_out,
   output logic irq_n_oe,
   // Analog front end controls, settled flag, task cancel and loop bandwidth
   output logic [2:0] transmit_output_pin,
   output logic receive_amp_invert,
   output logic tx_buffer_enable,
   output logic filters_enable,
   output logic extraction_enable,
   output logic outputs_settled,
   output logic task_cancel,
   output logic [1:0] loop_bandwidth_eff
);

   // ********************************
   // State
   // ********************************
   typedef struct packed {
      mode_bits_t mode;           // Mode register
      logic [7:0] control;        // Control register
      status_bits_t stat;         // Status flags
      logic [7:0] rdata;          // Read data
      logic [4:0] settle_cnt;     // Symbols left until settled
      logic empty_clear_pend;     // Empty clear waits for symbol tick
      logic [2:0] tx_out;         // Symbol at transmit output
      logic inv_rx;               // Receive amp polarity
      logic tx_buf_en;            // Output buffer enable
      logic filt_en;              // Filters and extraction enable
      logic settled;              // Outputs settled
      logic cancel;               // Task cancel pulse
      logic [1:0] bw_eff;         // Effective loop bandwidth
      logic irq_oe;               // Interrupt pin driven low
      logic free_d;               // Previous ready/done levels for edges
      logic empty_d;
   } bank_state_t;

   bank_state_t q_reg;
   bank_state_t q_next;
   logic symbol_tick;

   // Symbol-rate enable; loop works only in receive and out of powersave
   symbol_clock_div u_div (
      .sys_clk(sys_clk),
      .rst(rst),
      .clock_divider_field(q_reg.control[CTRL_DIV_LSB +: 2]),
      .loop_bandwidth_sel(q_reg.bw_eff),
      .loop_enable(!q_reg.mode.tx_mode && !q_reg.mode.powersave_sel),
      .phase_nudge(pll_phase_nudge),
      .symbol_tick(symbol_tick)
   );

   // Negate a symbol for polarity inversion
   function automatic logic [2:0] neg_sym(input logic [2:0] s);
      neg_sym = 3'h0 - s;
   endfunction

   // ********************************
   // Next-state logic
   // ********************************
   always_comb begin
      logic mode_wr;
      logic task_wr;
      logic real_task;
      logic silent_set;
      logic mode_change;
      logic stat_rd;
      logic free_rise;
      logic empty_cond;
      logic free_set;
      logic empty_set;
      logic ovf_set;
      logic [2:0] sym;
      mode_bits_t new_mode;
      mode_wr = 1'b0;
      task_wr = 1'b0;
      real_task = 1'b0;
      silent_set = 1'b0;
      mode_change = 1'b0;
      stat_rd = 1'b0;
      free_rise = 1'b0;
      empty_cond = 1'b0;
      free_set = 1'b0;
      empty_set = 1'b0;
      ovf_set = 1'b0;
      sym = SYM_MID;
      new_mode = q_reg.mode;
      q_next = q_reg;
      q_next.cancel = 1'b0;

      // Decode register port strobes
      mode_wr = reg_wr && reg_addr == ADDR_MODE;
      task_wr = reg_wr && reg_addr == ADDR_COMMAND;
      stat_rd = reg_rd && reg_addr == ADDR_STATUS;
      real_task = task_wr && reg_wdata != TASK_NULL && reg_wdata != TASK_RESET;
      if (mode_wr) begin
         // Bits 2-0 are don't care; the host keeps them zero
         new_mode = {reg_wdata[MODE_IRQ_EN_BIT], reg_wdata[MODE_INVERT_BIT], reg_wdata[MODE_TX_BIT],
                     reg_wdata[MODE_EYE_BIT], reg_wdata[MODE_POWERSAVE_SEL_BIT]};
         mode_change = new_mode.tx_mode != q_reg.mode.tx_mode ||
                       new_mode.powersave_sel != q_reg.mode.powersave_sel;
         q_next.mode = new_mode;
         // Any change of direction cancels the current task
         if (new_mode.tx_mode != q_reg.mode.tx_mode) begin
            q_next.cancel = 1'b1;
         end
         // Leaving powersave starts the settling count
         if (q_reg.mode.powersave_sel && !new_mode.powersave_sel) begin
            q_next.settle_cnt = 5'(SETTLE_SYMBOLS);
         end
      end
      if (reg_wr && reg_addr == ADDR_CONTROL) begin
         q_next.control = reg_wdata;
      end
      silent_set = mode_change || (task_wr && reg_wdata == TASK_RESET);

      // Read data: flags as sampled before the clear of this read
      q_next.rdata = 8'h00;
      if (stat_rd) begin
         q_next.rdata[STAT_IRQ_BIT] = q_reg.stat.irq_req;
         q_next.rdata[STAT_FREE_BIT] = q_reg.stat.block_buffer_free;
         q_next.rdata[STAT_EMPTY_BIT] = q_reg.stat.interleave_empty;
         q_next.rdata[STAT_OVF_BIT] = q_reg.stat.deinterleave_overflow;
      end

      // Event detection on the datapath levels
      free_rise = (q_reg.mode.tx_mode ? tx_task_ready : rx_task_done) && !q_reg.free_d;
      q_next.free_d = q_reg.mode.tx_mode ? tx_task_ready : rx_task_done;
      empty_cond = q_reg.mode.tx_mode && interleave_level < 2'h2;
      q_next.empty_d = empty_cond;
      free_set = free_rise && !q_reg.stat.block_buffer_free;
      empty_set = empty_cond && !q_reg.empty_d && !q_reg.stat.interleave_empty;
      ovf_set = !q_reg.mode.tx_mode && rx_task_late && !q_reg.stat.deinterleave_overflow;

      // Buffer free: clear on task, set by hardware wins
      if (real_task) begin
         q_next.stat.block_buffer_free = 1'b0;
      end
      if (free_rise) begin
         q_next.stat.block_buffer_free = 1'b1;
      end
      if (silent_set) begin
         q_next.stat.block_buffer_free = 1'b1;
      end

      // Interleave empty: clear on next symbol tick after a task
      if (real_task) begin
         q_next.empty_clear_pend = 1'b1;
      end
      if (q_reg.empty_clear_pend && symbol_tick) begin
         q_next.stat.interleave_empty = 1'b0;
         q_next.empty_clear_pend = 1'b0;
      end
      if (empty_set) begin
         q_next.stat.interleave_empty = 1'b1;
         q_next.empty_clear_pend = 1'b0;
      end
      if (silent_set) begin
         q_next.stat.interleave_empty = 1'b1;
         q_next.empty_clear_pend = 1'b0;
      end
      if (!q_next.mode.tx_mode) begin
         q_next.stat.interleave_empty = 1'b0;
      end

      // Overflow: clears on read, reset task or mode change; a new event wins
      if (stat_rd || silent_set) begin
         q_next.stat.deinterleave_overflow = 1'b0;
      end
      if (ovf_set) begin
         q_next.stat.deinterleave_overflow = 1'b1;
      end
      if (q_next.mode.tx_mode) begin
         q_next.stat.deinterleave_overflow = 1'b0;
      end

      // Interrupt request: cleared by read, any new set wins
      if (stat_rd) begin
         q_next.stat.irq_req = 1'b0;
      end
      if ((free_set || empty_set) && !silent_set) begin
         q_next.stat.irq_req = 1'b1;
      end
      if (ovf_set) begin
         q_next.stat.irq_req = 1'b1;
      end
      q_next.irq_oe = q_next.mode.irq_pin_enable && q_next.stat.irq_req;

      // Settling counter runs on the symbol enable
      if (symbol_tick && q_reg.settle_cnt != 5'h00 && !(mode_wr && q_next.settle_cnt != q_reg.settle_cnt)) begin
         q_next.settle_cnt = q_reg.settle_cnt - 5'h01;
      end
      q_next.settled = q_next.settle_cnt == 5'h00 && !q_next.mode.powersave_sel;

      // Power domains
      q_next.filt_en = !q_next.mode.powersave_sel;
      q_next.tx_buf_en = !q_next.mode.powersave_sel;

      // Loop bandwidth: ignored in transmit, wide while acquiring
      if (q_next.mode.tx_mode) begin
         q_next.bw_eff = BW_HOLD;
      end else if (acquire_active) begin
         q_next.bw_eff = BW_WIDE;
      end else begin
         q_next.bw_eff = q_next.control[CTRL_BW_LSB +: 2];
      end

      // Transmit output source selection
      if (q_next.mode.powersave_sel) begin
         sym = SYM_MID;
      end else if (!q_next.mode.tx_mode && q_next.mode.rx_eye_test) begin
         sym = rx_eq_symbol;
      end else if (q_next.mode.tx_mode && q_next.stat.interleave_empty) begin
         sym = SYM_MID;
      end else if (q_next.mode.tx_mode) begin
         sym = tx_symbol_in;
      end
      q_next.tx_out = q_next.mode.symbol_invert ? neg_sym(sym) : sym;
      // Receive amp shows +3 below bias unless inverted
      q_next.inv_rx = q_next.mode.symbol_invert;
   end

   // ********************************
   // Registers
   // ********************************
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         q_reg <= '0;
         q_reg.mode <= mode_bits_t'(MODE_RESET[7:3]);
         q_reg.control <= CTRL_RESET;
         q_reg.stat.block_buffer_free <= 1'b1;
         q_reg.filt_en <= 1'b1;
         q_reg.tx_buf_en <= 1'b1;
         q_reg.settled <= 1'b1;
      end else begin
         q_reg <= q_next;
      end
   end

   // Outputs straight from flip-flops; irq_n_out is tied low
   assign reg_rdata = q_reg.rdata;
   assign irq_n_out = 1'b0;
   assign irq_n_oe = q_reg.irq_oe;
   assign transmit_output_pin = q_reg.tx_out;
   assign receive_amp_invert = q_reg.inv_rx;
   assign tx_buffer_enable = q_reg.tx_buf_en;
   assign filters_enable = q_reg.filt_en;
   assign extraction_enable = q_reg.filt_en;
   assign outputs_settled = q_reg.settled;
   assign task_cancel = q_reg.cancel;
   assign loop_bandwidth_eff = q_reg.bw_eff;

   // ********************************
   // Assertions
   // ********************************
   property p_irq_pin;
      @(posedge sys_clk) disable iff (rst) irq_n_oe == (q_reg.mode.irq_pin_enable && q_reg.stat.irq_req);
   endproperty
   a_irq_pin: assert property (p_irq_pin) else $error("irq pin mismatch");
   property p_rd_clear;
      @(posedge sys_clk) disable iff (rst) (reg_rd && reg_addr == ADDR_STATUS && !rx_task_late
         && !tx_task_ready && !rx_task_done && !(q_reg.mode.tx_mode && interleave_level < 2'h2))
         |=> !q_reg.stat.irq_req && !irq_n_oe;
   endproperty
   a_rd_clear: assert property (p_rd_clear) else $error("read did not clear request");
   property p_rd_value;
      @(posedge sys_clk) disable iff (rst) (reg_rd && reg_addr == ADDR_STATUS)
         |=> reg_rdata[STAT_IRQ_BIT] == $past(q_reg.stat.irq_req);
   endproperty
   a_rd_value: assert property (p_rd_value) else $error("read value not pre-clear");
   property p_task_free;
      @(posedge sys_clk) disable iff (rst) (reg_wr && reg_addr == ADDR_COMMAND && reg_wdata != TASK_NULL
         && reg_wdata != TASK_RESET && !tx_task_ready && !rx_task_done) |=> !q_reg.stat.block_buffer_free;
   endproperty
   a_task_free: assert property (p_task_free) else $error("free not cleared by task");
   property p_silent;
      @(posedge sys_clk) disable iff (rst) (reg_wr && reg_addr == ADDR_COMMAND && reg_wdata == TASK_RESET)
         |=> q_reg.stat.block_buffer_free && !q_reg.stat.deinterleave_overflow;
   endproperty
   a_silent: assert property (p_silent) else $error("reset task effect missing");
   property p_rx_empty;
      @(posedge sys_clk) disable iff (rst) !q_reg.mode.tx_mode |-> !q_reg.stat.interleave_empty;
   endproperty
   a_rx_empty: assert property (p_rx_empty) else $error("empty set in receive");
   property p_tx_ovf;
      @(posedge sys_clk) disable iff (rst) q_reg.mode.tx_mode |-> !q_reg.stat.deinterleave_overflow;
   endproperty
   a_tx_ovf: assert property (p_tx_ovf) else $error("overflow set in transmit");
   property p_ovf_irq;
      @(posedge sys_clk) disable iff (rst) $rose(q_reg.stat.deinterleave_overflow) |-> q_reg.stat.irq_req;
   endproperty
   a_ovf_irq: assert property (p_ovf_irq) else $error("overflow without request");
   property p_powersave_sel;
      @(posedge sys_clk) disable iff (rst) q_reg.mode.powersave_sel |-> !filters_enable && !tx_buffer_enable;
   endproperty
   a_powersave_sel: assert property (p_powersave_sel) else $error("powersave not applied");
   property p_bw_tx;
      @(posedge sys_clk) disable iff (rst) q_reg.mode.tx_mode |-> loop_bandwidth_eff == BW_HOLD;
   endproperty
   a_bw_tx: assert property (p_bw_tx) else $error("bandwidth used in transmit");
   c_irq: cover property (@(posedge sys_clk) disable iff (rst) $rose(irq_n_oe));
   c_ovf: cover property (@(posedge sys_clk) disable iff (rst) $rose(q_reg.stat.deinterleave_overflow));
   c_empty: cover property (@(posedge sys_clk) disable iff (rst) $rose(q_reg.stat.interleave_empty));
   c_settle: cover property (@(posedge sys_clk) disable iff (rst) $rose(outputs_settled));

endmodule

// [src/symbol_clock_div.sv]
// Symbol-rate enable divider with loop bandwidth steering
`timescale 1ns/1ns
module symbol_clock_div
   import modem_regs_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Configuration
   input wire logic [1:0] clock_divider_field,
   input wire logic [1:0] loop_bandwidth_sel,
   input wire logic loop_enable,
   input wire logic phase_nudge,
   // Output
   output logic symbol_tick
);

   // ********************************
   // State
   // ********************************
   typedef struct packed {
      logic [12:0] count;
      logic tick;
   } div_state_t;

   div_state_t q_reg;
   div_state_t q_next;
   logic [12:0] period;

   // Division ratio 512 << code
   always_comb begin
      period = DIV_BASE << clock_divider_field;
   end

   // Next state: in hold or with the loop off, the count runs at the nominal period only
   always_comb begin
      q_next = q_reg;
      q_next.tick = 1'b0;
      if (q_reg.count >= period - 13'h0001) begin
         q_next.count = 13'h0000;
         q_next.tick = 1'b1;
      end else if (loop_enable && loop_bandwidth_sel != BW_HOLD && phase_nudge) begin
         // Feedback advances phase by one clock; no tracked frequency is kept
         q_next.count = q_reg.count + 13'h0002;
      end else begin
         q_next.count = q_reg.count + 13'h0001;
      end
   end

   // Register
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         q_reg <= '0;
      end else begin
         q_reg <= q_next;
      end
   end

   assign symbol_tick = q_reg.tick;

endmodule

// [testbench/modem_host_model.sv]
// Host microcontroller model that drives the register port of the mode/status bank
`timescale 1ns/1ns
module modem_host_model
   import modem_regs_pkg::*;
(
   // Clock
   input wire logic sys_clk,
   // Register port
   output logic [3:0] reg_addr,
   output logic [7:0] reg_wdata,
   output logic reg_wr,
   output logic reg_rd,
   input wire logic [7:0] reg_rdata
);
   // ********************************
   // Idle bus
   // ********************************
   initial begin
      reg_addr = 4'h0;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end

   // ********************************
   // Bus cycles
   // ********************************
   // One-cycle write; released lines show the inverse so stale values never pass
   task automatic reg_write(input logic [3:0] addr, input logic [7:0] data);
      @(posedge sys_clk);
      reg_addr <= addr;
      reg_wdata <= data;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      reg_addr <= ~addr;
      reg_wdata <= ~data;
   endtask

   // Low mode bits are always sent as zero
   task automatic mode_write(input logic [7:0] mode);
      reg_write(ADDR_MODE, {mode[7:3], 3'h0});
   endtask

   // One-cycle read; data taken in the cycle after the strobe only
   task automatic reg_read(input logic [3:0] addr, output logic [7:0] data);
      @(posedge sys_clk);
      reg_addr <= addr;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      reg_addr <= ~addr;
      #1 data = reg_rdata;
   endtask
endmodule

// [testbench/modem_mode_status_regs_test.sv]
// Self-checking testbench of the modem mode/status register bank
`timescale 1ns/1ns
module modem_mode_status_regs_test
   import modem_regs_pkg::*;
;
   // ********************************
   // Signals
   // ********************************
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic [3:0] reg_addr;
   logic [7:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   logic [7:0] reg_rdata;
   logic tx_task_ready = 1'b0;
   logic rx_task_done = 1'b0;
   logic [1:0] interleave_level = 2'h0;
   logic rx_task_late = 1'b0;
   logic acquire_active = 1'b0;
   logic pll_phase_nudge = 1'b0; // Tied: random nudges would blur tick timing
   logic [2:0] tx_symbol_in = 3'h0;
   logic [2:0] rx_eq_symbol = 3'h0;
   logic irq_n_out, irq_n_oe, receive_amp_invert, tx_buffer_enable, filters_enable;
   logic extraction_enable, outputs_settled, task_cancel;
   logic [2:0] transmit_output_pin;
   logic [1:0] loop_bandwidth_eff;
   int errors = 0;
   int checks_done = 0;
   logic [31:0] seed = 32'h0000_5C2B; // Fixed seed for repeatable runs
   logic [7:0] d;
   logic [2:0] s;
   logic inv;

   // Clock of 8 ns
   always #4 sys_clk = ~sys_clk;

   // ********************************
   // Instances
   // ********************************
   modem_host_model i_host (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
   modem_mode_status_regs i_dut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .tx_task_ready(tx_task_ready), .rx_task_done(rx_task_done), .interleave_level(interleave_level),
      .rx_task_late(rx_task_late), .acquire_active(acquire_active), .pll_phase_nudge(pll_phase_nudge),
      .tx_symbol_in(tx_symbol_in), .rx_eq_symbol(rx_eq_symbol), .irq_n_out(irq_n_out),
      .irq_n_oe(irq_n_oe), .transmit_output_pin(transmit_output_pin),
      .receive_amp_invert(receive_amp_invert), .tx_buffer_enable(tx_buffer_enable),
      .filters_enable(filters_enable), .extraction_enable(extraction_enable),
      .outputs_settled(outputs_settled), .task_cancel(task_cancel), .loop_bandwidth_eff(loop_bandwidth_eff));

   // ********************************
   // Helpers
   // ********************************
   // Random four-level symbol from the xorshift stream
   function automatic logic [2:0] next_sym();
      logic [2:0] table_v [4];
      table_v = '{3'h1, 3'h3, 3'h7, 3'h5};
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return table_v[seed[1:0]];
   endfunction

   // Expected transmit symbol for the polarity setting
   function automatic logic [2:0] exp_tx(input logic [2:0] sym, input logic invert);
      return invert ? (~sym + 3'h1) : sym;
   endfunction

   task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic read_check(input logic [3:0] addr, input logic [7:0] exp);
      logic [7:0] v;
      i_host.reg_read(addr, v);
      check_byte(v, exp);
   endtask

   task automatic cycles(input int n);
      repeat (n) @(posedge sys_clk);
   endtask

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // ********************************
   // Watchdog
   // ********************************
   initial begin
      cycles(40000);
      errors++;
      give_verdict();
   end

   // ********************************
   // Main sequence
   // ********************************
   initial begin
      cycles(4);
      rst <= 1'b0;
      read_check(ADDR_STATUS, 8'h40);
      check_byte({7'h0, irq_n_oe}, 8'h00);
      $display("test reset done");
      // Transmit entry: silent sets, task cancelled, loop held
      i_host.mode_write(8'hA0);
      #1 check_byte({7'h0, task_cancel}, 8'h01);
      cycles(2);
      check_byte({6'h0, loop_bandwidth_eff}, {6'h0, BW_HOLD});
      read_check(ADDR_STATUS, 8'h60);
      interleave_level <= 2'h3;
      i_host.reg_write(ADDR_COMMAND, 8'h05);
      cycles(520);
      read_check(ADDR_STATUS, 8'h00);
      interleave_level <= 2'h1;
      tx_symbol_in <= next_sym();
      cycles(4);
      check_byte({7'h0, irq_n_oe}, 8'h01);
      check_byte({7'h0, irq_n_out}, 8'h00);
      check_byte({5'h0, transmit_output_pin}, {5'h0, SYM_MID});
      read_check(ADDR_STATUS, 8'hA0);
      check_byte({7'h0, irq_n_oe}, 8'h00);
      read_check(ADDR_STATUS, 8'h20);
      tx_task_ready <= 1'b1;
      cycles(2);
      read_check(ADDR_STATUS, 8'hE0);
      tx_task_ready <= 1'b0;
      interleave_level <= 2'h3;
      i_host.reg_write(ADDR_COMMAND, 8'h05);
      cycles(520);
      for (int i = 0; i < 8; i++) begin
         inv = seed[7];
         s = next_sym();
         i_host.mode_write({1'b1, inv, 6'h20});
         tx_symbol_in <= s;
         cycles(4);
         check_byte({5'h0, transmit_output_pin}, {5'h0, exp_tx(s, inv)});
         check_byte({7'h0, receive_amp_invert}, {7'h0, inv});
      end
      $display("test transmit done");
      // Receive entry and loop bandwidth
      i_host.mode_write(8'h80);
      #1 check_byte({7'h0, task_cancel}, 8'h01);
      read_check(ADDR_STATUS, 8'h40);
      s = next_sym() & 3'h3;
      // Host writes one random loop setting from the stream; it reaches the loop unchanged
      i_host.reg_write(ADDR_CONTROL, {6'h00, s[1:0]});
      cycles(2);
      check_byte({6'h0, loop_bandwidth_eff}, {6'h0, s[1:0]});
      // Acquisition must override even the hold setting
      i_host.reg_write(ADDR_CONTROL, {6'h00, BW_HOLD});
      acquire_active <= 1'b1;
      cycles(2);
      check_byte({6'h0, loop_bandwidth_eff}, {6'h0, BW_WIDE});
      acquire_active <= 1'b0;
      i_host.reg_write(ADDR_CONTROL, {6'h00, BW_WIDE});
      // Overflow set, read clear, reset-task clear
      rx_task_late <= 1'b1;
      cycles(1);
      rx_task_late <= 1'b0;
      cycles(2);
      read_check(ADDR_STATUS, 8'hD0);
      read_check(ADDR_STATUS, 8'h40);
      rx_task_late <= 1'b1;
      cycles(1);
      rx_task_late <= 1'b0;
      i_host.reg_write(ADDR_COMMAND, TASK_RESET);
      i_host.reg_read(ADDR_STATUS, d);
      check_byte(d & 8'h50, 8'h40);
      i_host.reg_write(ADDR_COMMAND, 8'h05);
      rx_task_done <= 1'b1;
      cycles(2);
      read_check(ADDR_STATUS, 8'hC0);
      rx_task_done <= 1'b0;
      $display("test receive done");
      // Eye test routing
      rx_eq_symbol <= next_sym();
      i_host.mode_write(8'h90);
      cycles(4);
      check_byte({5'h0, transmit_output_pin}, {5'h0, rx_eq_symbol});
      // Powersave and settling
      i_host.mode_write(8'h88);
      cycles(2);
      check_byte({5'h0, filters_enable, extraction_enable, tx_buffer_enable}, 8'h00);
      i_host.mode_write(8'h80);
      cycles(100);
      check_byte({7'h0, outputs_settled}, 8'h00);
      cycles(SETTLE_SYMBOLS * 512 + 900);
      check_byte({7'h0, outputs_settled}, 8'h01);
      check_byte({5'h0, filters_enable, extraction_enable, tx_buffer_enable}, 8'h07);
      read_check(4'hF, 8'h00);
      read_check(ADDR_MODE, 8'h00);
      $display("test powersave done");
      give_verdict();
   end
endmodule
